//--- fsl_fault_status.v
// fault word, indicator outputs, registers and log control
//
// Local design decisions: strobed register access and the register offsets.
`include "fsl_defs.vh"
`default_nettype none
// Functional notes
// - zone no flow sets 0800, purge no flow sets 1000, purge no flow critical
// - clipping 8000, zero voltage tolerance 4000, over range 2000
// - zero filter 0100, gain out of range 0200, converter 0400
// - enclosure temp 0001, bench temp 0002, manifold pressure 0004
// - serial error 0008, open loop 0010, configuration mismatch 0080
// - loop fault only when dual loop option fitted and a loop is open
// - over range when any zone concentration exceeds measurement range
// - zone fault clears only when that zone is sampled again
// - indicator and relays drop once no fault remains
// - log keeps the latest 20 records
// - log record on every fault status change, set or clear
// - record holds all fault flags plus detection time stamp
// - enter with right while viewing log empties the log
// - up and down held through power-up to second beep wipes all
// - fault code is the OR of all asserted fault bits
// - any fault lights indicator and enabled relay and audible alarm
module fsl_fault_status (
  input  wire                     i_mclk,
  input  wire                     i_nrst,
  input  wire [`FSL_ZW-1:0]       i_zone_idx,
  input  wire                     i_zone_sample,
  input  wire                     i_zone_no_flow,
  input  wire [`FSL_ZONES-1:0]    i_zone_over_range,
  input  wire                     i_purge_no_flow,
  input  wire                     i_clipping,
  input  wire                     i_zero_voltage_tolerance_fault,
  input  wire                     i_zero_filter,
  input  wire                     i_gain_range,
  input  wire                     i_converter_fault,
  input  wire                     i_box_temp,
  input  wire                     i_bench_temp,
  input  wire                     i_pressure,
  input  wire                     i_serial_err,
  input  wire                     i_loop_option,
  input  wire [1:0]               i_loop_open,
  input  wire                     i_config_err,
  input  wire [`FSL_TS_W-1:0]     i_timestamp,
  input  wire                     i_key_enter,
  input  wire                     i_key_right,
  input  wire                     i_key_up,
  input  wire                     i_key_down,
  input  wire                     i_powerup_beep,
  input  wire [3:0]               i_addr,
  input  wire [31:0]              i_wdata,
  input  wire                     i_wr,
  input  wire                     i_rd,
  output reg  [31:0]              o_rdata,
  output reg  [15:0]              o_fault_code,
  output reg                      o_fault_led,
  output reg                      o_fault_relay,
  output reg                      o_audible,
  output reg                      o_factory_wipe,
  output wire                     o_irq
);
  // ****************************************
  // state
  // ****************************************
  reg  [`FSL_ZONES-1:0] zone_flow_r;
  reg  [`FSL_ZONES-1:0] zone_flow_nxt;
  reg  [15:0]           fault_nxt;
  reg  [15:0]           prev_code_r;
  reg  [1:0]            irq_stat_r;
  reg  [1:0]            irq_mask_r;
  reg  [7:0]            ctrl_r;
  reg  [`FSL_LOG_AW-1:0] log_sel_r;
  reg                   boot_r;
  reg  [1:0]            beep_cnt_r;
  reg                   log_clr_r;
  reg                   log_wr_r;
  wire [`FSL_REC_W-1:0] log_rec;
  wire [`FSL_LOG_AW-1:0] log_count;
  wire                  code_change;
  wire                  clear_keys;
  wire                  log_clear;

  // ****************************************
  // fault word assembly
  // ****************************************
  function [15:0] bit_if;
    input        c;
    input [15:0] b;
    begin
      bit_if = c ? b : 16'h0000;
    end
  endfunction

  always @* begin
    zone_flow_nxt = zone_flow_r;
    if (i_zone_sample)
      zone_flow_nxt[i_zone_idx] = i_zone_no_flow;
    fault_nxt = bit_if(|zone_flow_r, `FSL_F_ZONE_FLOW)
      | bit_if(i_purge_no_flow, `FSL_F_PURGE_FLOW)
      | bit_if(i_clipping, `FSL_F_CLIPPING)
      | bit_if(i_zero_voltage_tolerance_fault, `FSL_F_ZERO_VOLT)
      | bit_if(|i_zone_over_range, `FSL_F_OVER_RANGE)
      | bit_if(i_zero_filter, `FSL_F_ZERO_FILTER)
      | bit_if(i_gain_range, `FSL_F_GAIN)
      | bit_if(i_converter_fault, `FSL_F_CONVERTER)
      | bit_if(i_box_temp, `FSL_F_BOX_TEMP)
      | bit_if(i_bench_temp, `FSL_F_BENCH_TEMP)
      | bit_if(i_pressure, `FSL_F_PRESSURE)
      | bit_if(i_serial_err, `FSL_F_SERIAL)
      | bit_if(i_loop_option & (|i_loop_open), `FSL_F_LOOP)
      | bit_if(i_config_err, `FSL_F_CONFIG);
    fault_nxt = fault_nxt & `FSL_F_VALID_MASK;
  end

  assign code_change = (o_fault_code != prev_code_r);
  assign clear_keys  = ctrl_r[`FSL_CTRL_LOG_VIEW] & i_key_enter & i_key_right;
  assign log_clear   = log_clr_r | o_factory_wipe;

  // ****************************************
  // fault word, indicators, wipe
  // ****************************************
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      zone_flow_r    <= {`FSL_ZONES{1'b0}};
      o_fault_code   <= 16'h0000;
      prev_code_r    <= 16'h0000;
      o_fault_led    <= 1'b0;
      o_fault_relay  <= 1'b0;
      o_audible      <= 1'b0;
      boot_r         <= 1'b1;
      beep_cnt_r     <= 2'd0;
      o_factory_wipe <= 1'b0;
      log_clr_r      <= 1'b0;
      log_wr_r       <= 1'b0;
    end else begin
      o_factory_wipe <= 1'b0;
      // keys must be held from power-up through the second beep
      if (boot_r) begin
        if (!(i_key_up & i_key_down)) begin
          boot_r <= 1'b0;
        end else if (i_powerup_beep) begin
          beep_cnt_r <= beep_cnt_r + 2'd1;
          if (beep_cnt_r + 2'd1 == `FSL_WIPE_BEEPS) begin
            o_factory_wipe <= 1'b1;
            boot_r         <= 1'b0;
          end
        end
      end
      if (o_factory_wipe) begin
        zone_flow_r  <= {`FSL_ZONES{1'b0}};
        o_fault_code <= 16'h0000;
        prev_code_r  <= 16'h0000;
      end else begin
        zone_flow_r  <= zone_flow_nxt;
        o_fault_code <= fault_nxt;
        prev_code_r  <= o_fault_code;
      end
      log_wr_r <= code_change & ~o_factory_wipe;
      log_clr_r <= clear_keys;
      o_fault_led   <= |o_fault_code;
      o_fault_relay <= (|o_fault_code) & ctrl_r[`FSL_CTRL_RELAY_EN];
      o_audible     <= (|o_fault_code) & ctrl_r[`FSL_CTRL_AUDIO_EN];
    end
  end

  // ****************************************
  // log
  // ****************************************
  fsl_log_mem u_log (
    .i_mclk  (i_mclk),
    .i_nrst  (i_nrst),
    .i_clear (log_clear),
    .i_wr    (log_wr_r),
    .i_rec   ({o_fault_code, i_timestamp}),
    .i_sel   (log_sel_r),
    .o_rec   (log_rec),
    .o_count (log_count)
  );

  // ****************************************
  // register port and interrupts
  // ****************************************
  assign o_irq = |(irq_stat_r & irq_mask_r);

  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_stat_r <= 2'b00;
      irq_mask_r <= 2'b00;
      ctrl_r     <= `FSL_CTRL_RST;
      log_sel_r  <= {`FSL_LOG_AW{1'b0}};
      o_rdata    <= 32'h0000_0000;
    end else begin
      // hardware set wins over write-one clear
      if (i_wr && i_addr == `FSL_A_IRQ_STAT)
        irq_stat_r <= (irq_stat_r & ~i_wdata[1:0]) |
                      {log_wr_r & ~(|o_fault_code), log_wr_r & (|o_fault_code)};
      else
        irq_stat_r <= irq_stat_r |
                      {log_wr_r & ~(|o_fault_code), log_wr_r & (|o_fault_code)};
      if (i_wr) begin
        case (i_addr)
          `FSL_A_IRQ_MASK: irq_mask_r <= i_wdata[1:0];
          `FSL_A_CTRL:     ctrl_r     <= i_wdata[7:0];
          `FSL_A_LOG_SEL:  log_sel_r  <= i_wdata[`FSL_LOG_AW-1:0];
          default: ;
        endcase
      end
      o_rdata <= 32'h0000_0000;
      if (i_rd) begin
        case (i_addr)
          `FSL_A_FAULT:     o_rdata <= {16'h0000, o_fault_code};
          `FSL_A_IRQ_STAT:  o_rdata <= {30'd0, irq_stat_r};
          `FSL_A_IRQ_MASK:  o_rdata <= {30'd0, irq_mask_r};
          `FSL_A_CTRL:      o_rdata <= {24'd0, ctrl_r};
          `FSL_A_LOG_CNT:   o_rdata <= {27'd0, log_count};
          `FSL_A_LOG_SEL:   o_rdata <= {27'd0, log_sel_r};
          `FSL_A_LOG_FLAGS: o_rdata <= {16'h0000, log_rec[`FSL_REC_W-1:`FSL_TS_W]};
          `FSL_A_LOG_TIME:  o_rdata <= log_rec[`FSL_TS_W-1:0];
          `FSL_A_ZONE_FLOW: o_rdata <= {16'h0000, zone_flow_r};
          default:          o_rdata <= 32'h0000_0000;
        endcase
      end
      // factory wipe also returns settings and events to their reset state
      if (o_factory_wipe) begin
        irq_stat_r <= 2'b00;
        irq_mask_r <= 2'b00;
        ctrl_r     <= `FSL_CTRL_RST;
        log_sel_r  <= {`FSL_LOG_AW{1'b0}};
      end
    end
  end
endmodule
`default_nettype wire

//--- fsl_defs.vh
// fault status and log constants
`ifndef FSL_DEFS_VH
`define FSL_DEFS_VH
`define FSL_F_BOX_TEMP     16'h0001
`define FSL_F_BENCH_TEMP   16'h0002
`define FSL_F_PRESSURE     16'h0004
`define FSL_F_SERIAL       16'h0008
`define FSL_F_LOOP         16'h0010
`define FSL_F_CONFIG       16'h0080
`define FSL_F_ZERO_FILTER  16'h0100
`define FSL_F_GAIN         16'h0200
`define FSL_F_CONVERTER    16'h0400
`define FSL_F_ZONE_FLOW    16'h0800
`define FSL_F_PURGE_FLOW   16'h1000
`define FSL_F_OVER_RANGE   16'h2000
`define FSL_F_ZERO_VOLT    16'h4000
`define FSL_F_CLIPPING     16'h8000
`define FSL_F_VALID_MASK   16'hFF9F
`define FSL_LOG_DEPTH      20
`define FSL_LOG_AW         5
`define FSL_ZONES          16
`define FSL_ZW             4
`define FSL_TS_W           32
`define FSL_REC_W          48
`define FSL_A_FAULT        4'h0
`define FSL_A_IRQ_STAT     4'h1
`define FSL_A_IRQ_MASK     4'h2
`define FSL_A_CTRL         4'h3
`define FSL_A_LOG_CNT      4'h4
`define FSL_A_LOG_SEL      4'h5
`define FSL_A_LOG_FLAGS    4'h6
`define FSL_A_LOG_TIME     4'h7
`define FSL_A_ZONE_FLOW    4'h8
`define FSL_CTRL_RST       8'h03
`define FSL_IRQ_SET        2'd0
`define FSL_IRQ_CLR        2'd1
`define FSL_CTRL_RELAY_EN  0
`define FSL_CTRL_AUDIO_EN  1
`define FSL_CTRL_LOG_VIEW  2
`define FSL_WIPE_BEEPS     2
`endif

//--- fsl_log_mem.v
// circular fault log storage
`include "fsl_defs.vh"
`default_nettype none
module fsl_log_mem (
  input  wire                        i_mclk,
  input  wire                        i_nrst,
  input  wire                        i_clear,
  input  wire                        i_wr,
  input  wire [`FSL_REC_W-1:0]       i_rec,
  input  wire [`FSL_LOG_AW-1:0]      i_sel,
  output reg  [`FSL_REC_W-1:0]       o_rec,
  output reg  [`FSL_LOG_AW-1:0]      o_count
);
  reg [`FSL_REC_W-1:0]  mem [0:`FSL_LOG_DEPTH-1];
  reg [`FSL_LOG_AW-1:0] wr_ptr_r;
  reg [`FSL_LOG_AW-1:0] rd_idx;
  localparam [`FSL_LOG_AW-1:0] DEPTH_N  = `FSL_LOG_DEPTH;
  localparam [`FSL_LOG_AW:0]   DEPTH_M1 = `FSL_LOG_DEPTH - 1;

  function [`FSL_LOG_AW-1:0] wrap_idx;
    input [`FSL_LOG_AW:0] v;
    begin
      if (v >= `FSL_LOG_DEPTH)
        wrap_idx = v[`FSL_LOG_AW-1:0] - DEPTH_N;
      else
        wrap_idx = v[`FSL_LOG_AW-1:0];
    end
  endfunction

  // sel 0 is newest record
  always @* begin
    rd_idx = wrap_idx({1'b0, wr_ptr_r} + DEPTH_M1 - {1'b0, i_sel});
  end

  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_ptr_r <= {`FSL_LOG_AW{1'b0}};
      o_count  <= {`FSL_LOG_AW{1'b0}};
      o_rec    <= {`FSL_REC_W{1'b0}};
    end else begin
      if (i_clear) begin
        wr_ptr_r <= {`FSL_LOG_AW{1'b0}};
        o_count  <= {`FSL_LOG_AW{1'b0}};
      end else if (i_wr) begin
        mem[wr_ptr_r] <= i_rec;
        wr_ptr_r <= wrap_idx({1'b0, wr_ptr_r} + 1'b1);
        if (o_count != `FSL_LOG_DEPTH)
          o_count <= o_count + 1'b1;
      end
      if (i_sel < o_count)
        o_rec <= mem[rd_idx];
      else
        o_rec <= {`FSL_REC_W{1'b0}};
    end
  end
endmodule
`default_nettype wire

//--- fsl_fault_status_chk.sv
// assertions on the fault status block ports
`default_nettype none
module fsl_fault_status_chk (
  input wire logic        i_mclk,
  input wire logic        i_nrst,
  input wire logic        i_zone_sample,
  input wire logic        i_zone_no_flow,
  input wire logic [15:0] i_zone_over_range,
  input wire logic        i_purge_no_flow,
  input wire logic        i_clipping,
  input wire logic        i_zero_voltage_tolerance_fault,
  input wire logic        i_gain_range,
  input wire logic        i_converter_fault,
  input wire logic        i_rd,
  input wire logic [3:0]  i_addr,
  input wire logic [31:0] o_rdata,
  input wire logic [15:0] o_fault_code,
  input wire logic        o_fault_led,
  input wire logic        o_fault_relay,
  input wire logic        o_audible,
  input wire logic        o_factory_wipe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  logic [5:0] prv;
  // fault levels one edge back
  always_ff @(posedge i_mclk or negedge i_nrst)
    if (!i_nrst) prv <= 6'h00;
    else prv <= {i_clipping, i_zero_voltage_tolerance_fault, |i_zone_over_range,
                 i_purge_no_flow, i_converter_fault, i_gain_range};
  sequence s_zone_fail;
    i_zone_sample && i_zone_no_flow;
  endsequence
  sequence s_quiet;
    !i_zone_sample [*2];
  endsequence
  a_zone_set: assert property (s_zone_fail |-> ##2 o_fault_code[11])
    else $error("zone no-flow not reported");
  a_zone_hold: assert property (s_quiet ##0 o_fault_code[11] |=> o_fault_code[11])
    else $error("zone fault dropped without a sample");
  a_crit_bits: assert property ($past(i_nrst) && !$past(o_factory_wipe) |->
    {o_fault_code[15:12], o_fault_code[10:9]} == prv)
    else $error("critical fault bits wrong");
  a_lamp_follow: assert property ($past(i_nrst) |->
    o_fault_led == ($past(o_fault_code) != 16'h0000))
    else $error("fault lamp does not follow code");
  a_relay_gate: assert property (o_fault_relay || o_audible |-> o_fault_led)
    else $error("relay or sounder without fault");
  a_rsvd_zero: assert property (o_fault_code[6:5] == 2'b00)
    else $error("reserved fault bits set");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h00000000)
    else $error("read data outside read slot");
  a_code_read: assert property ($past(i_rd) && $past(i_addr) == 4'h0 |->
    o_rdata[15:0] == $past(o_fault_code))
    else $error("fault code read mismatch");
  a_wipe_pulse: assert property (o_factory_wipe |=> !o_factory_wipe)
    else $error("wipe pulse too long");
endmodule
`default_nettype wire

//--- fsl_rd_model.sv
// remote display model: mirrors the fault word at each poll
`default_nettype none
module fsl_rd_model #(parameter int POLL = 8) (
  input  wire logic        i_mclk,
  input  wire logic        i_nrst,
  input  wire logic [15:0] i_code,
  output var  logic [15:0] o_mirror
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt;
  always_ff @(posedge i_mclk or negedge i_nrst)
    if (!i_nrst) begin
      cnt <= 0;
      o_mirror <= 16'h0000;
    end else begin
      cnt <= (cnt == POLL - 1) ? 0 : cnt + 1;
      if (cnt == POLL - 1) o_mirror <= i_code;
    end
endmodule
`default_nettype wire

//--- fsl_fault_status_tb.sv
// self-checking bench for the fault status and log block
`default_nettype none
module fsl_fault_status_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk = 1'b0, nrst = 1'b0, zs = 1'b0, znf = 1'b0, lopt = 1'b0;
  logic        beep = 1'b0, wr = 1'b0, rd = 1'b0, rdq = 1'b0;
  logic [15:0] f = 16'h0000, zor = 16'h0000, code, mirror, v;
  logic [3:0]  zidx = 4'h0, addr = 4'h0, k = 4'h3;
  logic [1:0]  lopen = 2'b00;
  logic [31:0] ts = 32'h0, wd = 32'h0, rdata, q[$];
  logic        led, relay, aud, wipe, irq;
  int          num_errors = 0, comparisons = 0, seen = 0;
  fsl_fault_status u_fsl_fault_status (
    .i_mclk(mclk), .i_nrst(nrst), .i_zone_idx(zidx), .i_zone_sample(zs),
    .i_zone_no_flow(znf), .i_zone_over_range(zor), .i_purge_no_flow(f[12]),
    .i_clipping(f[15]), .i_zero_voltage_tolerance_fault(f[14]), .i_zero_filter(f[8]),
    .i_gain_range(f[9]), .i_converter_fault(f[10]), .i_box_temp(f[0]), .i_bench_temp(f[1]),
    .i_pressure(f[2]), .i_serial_err(f[3]), .i_loop_option(lopt), .i_loop_open(lopen),
    .i_config_err(f[7]), .i_timestamp(ts), .i_key_enter(k[3]), .i_key_right(k[2]),
    .i_key_up(k[1]), .i_key_down(k[0]), .i_powerup_beep(beep), .i_addr(addr),
    .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_fault_code(code),
    .o_fault_led(led), .o_fault_relay(relay), .o_audible(aud), .o_factory_wipe(wipe),
    .o_irq(irq));
  fsl_rd_model #(.POLL(8)) u_fsl_rd_model (
    .i_mclk(mclk), .i_nrst(nrst), .i_code(code), .o_mirror(mirror));
  always #12.5 mclk = ~mclk;
  task automatic chk(input string n, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    q.push_back(e);
    @(posedge mclk);
    rd <= 1'b0;
  endtask
  task automatic zone(input logic [3:0] z, input logic nf);
    @(posedge mclk);
    zidx <= z;
    znf <= nf;
    zs <= 1'b1;
    @(posedge mclk);
    zs <= 1'b0;
    cyc(2);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // read data checked one cycle after each read
  always @(posedge mclk) begin
    if (rdq) chk("rdata", rdata, q.pop_front());
    rdq <= rd;
  end
  initial begin
    cyc(20000);
    num_errors++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'hd82a1d4d));
    cyc(4);
    nrst <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      cyc(2);
      beep <= 1'b1;
      @(posedge mclk) beep <= 1'b0;
    end
    repeat (4) @(posedge mclk) if (wipe === 1'b1) seen++;
    chk("wipe", seen, 1);
    k <= 4'h0;
    rreg(4'h3, 32'h3);
    rreg(4'h4, 32'h0);
    rreg(4'hF, 32'h0);
    for (int i = 0; i < 16; i++) if (((16'hD78F >> i) & 1) != 0) begin
      @(posedge mclk) f <= 16'h1 << i;
      rreg(4'h0, 32'h1 << i);
      @(posedge mclk);
      f <= 16'h0000;
      ts <= $urandom;
      cyc(3);
    end
    rreg(4'h4, 32'd20);
    wreg(4'h5, 32'h0);
    cyc(1);
    rreg(4'h6, 32'h0);
    rreg(4'h7, ts);
    wreg(4'h5, 32'h1);
    cyc(1);
    rreg(4'h6, 32'h8000);
    v = 16'($urandom) & 16'hD78F;
    @(posedge mclk);
    f <= v;
    lopen <= 2'b11;
    rreg(4'h0, {16'h0, v});
    lopt <= 1'b1;
    zor <= 16'h1 << $urandom_range(15);
    rreg(4'h0, {16'h0, v | 16'h2010});
    cyc(9);
    chk("mirror", mirror, v | 16'h2010);
    chk("lamps", {led, relay, aud}, 3'b111);
    f <= 16'h0000;
    zor <= 16'h0000;
    lopt <= 1'b0;
    cyc(3);
    chk("lamps", {led, relay, aud}, 3'b000);
    zone(4'h3, 1'b1);
    rreg(4'h0, 32'h0800);
    rreg(4'h8, 32'h8);
    zone(4'h5, 1'b0);
    rreg(4'h0, 32'h0800);
    zone(4'h3, 1'b0);
    rreg(4'h0, 32'h0);
    wreg(4'h1, 32'h3);
    wreg(4'h2, 32'h1);
    rreg(4'h1, 32'h0);
    @(posedge mclk) f <= 16'h0004;
    cyc(4);
    chk("irq", irq, 1'b1);
    wreg(4'h2, 32'h0);
    cyc(1);
    chk("irq", irq, 1'b0);
    wreg(4'h1, 32'h1);
    rreg(4'h1, 32'h0);
    @(posedge mclk) f <= 16'h0000;
    cyc(4);
    rreg(4'h1, 32'h2);
    wreg(4'h3, 32'h7);
    @(posedge mclk) k <= 4'hC;
    cyc(3);
    k <= 4'h0;
    rreg(4'h4, 32'h0);
    cyc(2);
    print_verdict();
  end
endmodule
bind fsl_fault_status fsl_fault_status_chk u_fsl_fault_status_chk (.*);
`default_nettype wire
